// ---- rtl/mgw_dev.sv ----
// Monitor end: pin functions, analog results, wake and fault relay
//
// Summary of operation
// - Default pin functions follow serial select strap
// - Writes to locked pin fields are ignored
// - Pins three to nine convert outside cell readout
// - Ratio bit 0 stores absolute code
// - Ratio bit 1 stores ratio to reference
// - Thresholds untouched when ratio bit changes
// - Host checks divider absolute versus ratiometric
// - Host runs divider check only at startup
// - Pins three to nine digital input or output by config
// - Select high makes pins eight, nine serial
// - Clock pin eight, data pin nine, isolated pins
// - Wake needs pin seven input and enable
// - Filtered high on pin seven wakes device
// - High wake pin blocks sleep and timeout
// - Low wake pin plus sleep or timeout sleeps
// - Sense fault from upper device on pin one
// - Drive fault downward on pin two, high
// - Host may use pin two as interrupt
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module mgw_dev
  import mgw_pkg::*;
#(
  parameter int WAKE_CYC = WAKE_US * CLK_MHZ
)(
  input  wire logic        clock,
  input  wire logic        resetn,
  mgw_link_if.dev          lnk,
  input  wire logic        cell_readout_busy,
  input  wire logic        comm_timeout,
  input  wire logic        afe_valid,
  input  wire logic [15:0] afe_abs_code,
  input  wire logic [15:0] afe_ratio_code,
  input  wire logic        spi_sdo,
  output logic             afe_req,
  output logic [2:0]       afe_chan,
  output logic             spi_mode,
  output logic             spi_sclk,
  output logic             spi_cs_n,
  output logic             spi_sdi,
  output logic             low_power,
  output logic             irq
);
  localparam int WCW = $clog2(WAKE_CYC + 1);

  initial begin
    if (WAKE_CYC < 1)
      $error("WAKE_CYC must be at least one");
  end

  typedef struct packed {
    logic                     sel_s1;
    logic                     sel_s2;
    logic [8:0]               pin_s1;
    logic [8:0]               pin_s2;
    logic [1:0]               iso_s1;
    logic [1:0]               iso_s2;
    logic                     loaded;
    logic [1:0]               load_cnt;
    logic [8:0][1:0]          cfg;
    logic [8:0]               dout;
    logic                     ratio_sel;
    logic                     wake_en;
    logic [15:0]              th_ot;
    logic [15:0]              th_ut;
    logic [NMEAS-1:0][15:0]   meas;
    logic [NST-1:0]           stat;
    logic [NST-1:0]           ien;
    logic [31:0]              rdata;
    logic                     conv_act;
    logic                     conv_wait;
    logic [2:0]               conv_idx;
    logic                     afe_req;
    logic                     low_power;
    logic [WCW-1:0]           wake_cnt;
    logic [8:0]               pin_o;
    logic [8:0]               pin_oe;
    logic                     sclk;
    logic                     cs_n;
    logic                     sdi;
    logic                     irq;
  } mgw_dev_st_t;

  mgw_dev_st_t st;
  mgw_dev_st_t next_st;

  // Single next-state process for the whole block
  always_comb begin
    logic        spi;
    logic        wake_ok;
    logic        wake_hi;
    logic        fault;
    logic [15:0] code;
    logic [NST-1:0] set;
    logic [NST-1:0] clr;
    next_st = st;
    set     = '0;
    clr     = '0;
    code    = '0;
    // Two flops on every pin and the strap
    next_st.sel_s1 = lnk.serial_mode_select_pin;
    next_st.sel_s2 = st.sel_s1;
    next_st.pin_s1 = lnk.pin;
    next_st.pin_s2 = st.pin_s1;
    next_st.iso_s1 = {lnk.isolated_plus_pin, lnk.isolated_minus_pin};
    next_st.iso_s2 = st.iso_s1;
    spi = st.sel_s2 & st.loaded;
    // Strap is caught only once the synchroniser has settled
    if (!st.loaded) begin
      next_st.load_cnt = st.load_cnt + 2'h1;
      if (st.load_cnt == STRAP_WT) begin
        next_st.loaded = 1'b1;
        next_st.cfg[P_SCK] = st.sel_s2 ? FN_DIN : FN_ANA;
        next_st.cfg[P_SDO] = st.sel_s2 ? FN_DOUT : FN_ANA;
      end
    end
    // Register writes
    if (lnk.reg_wr) begin
      case (lnk.reg_addr)
        A_CFG: begin
          for (int i = 0; i < NPIN; i++) begin
            // Fault pins always locked, serial pins in serial mode
            if (!(i == P_FIN || i == P_FOUT ||
                  ((i == P_SCK || i == P_SDO) && spi)) && st.loaded)
              next_st.cfg[i] = lnk.reg_wdata[2*i +: 2];
          end
        end
        A_DOUT: next_st.dout = lnk.reg_wdata[8:0];
        A_CTRL: begin
          // Thresholds stay as written
          next_st.ratio_sel = lnk.reg_wdata[C_RATIO];
          next_st.wake_en   = lnk.reg_wdata[C_WAKE];
          if (lnk.reg_wdata[C_CONV] && !st.conv_act) begin
            next_st.conv_act = 1'b1;
            next_st.conv_idx = '0;
          end
        end
        A_TH: begin
          next_st.th_ot = lnk.reg_wdata[15:0];
          next_st.th_ut = lnk.reg_wdata[31:16];
        end
        A_CLR:   clr = lnk.reg_wdata[NST-1:0];
        A_IEN:   next_st.ien = lnk.reg_wdata[NST-1:0];
        default: ;
      endcase
    end
    // Register reads; data stand one cycle later
    next_st.rdata = '0;
    if (lnk.reg_rd) begin
      if ((lnk.reg_addr & MEAS_MSK) == A_MEAS)
        next_st.rdata = {16'h0000, st.meas[lnk.reg_addr[4:2]]};
      else begin
        case (lnk.reg_addr)
          A_CFG:   next_st.rdata = {14'h0000, st.cfg};
          A_DOUT:  next_st.rdata = {23'h000000, st.dout};
          A_DIN:   next_st.rdata = {23'h000000, st.pin_s2};
          A_CTRL:  next_st.rdata = {27'h0000000, st.conv_act,
                     st.low_power, 1'b0, st.wake_en, st.ratio_sel};
          A_TH:    next_st.rdata = {st.th_ut, st.th_ot};
          A_STAT:  next_st.rdata = {28'h0000000, st.stat};
          A_IEN:   next_st.rdata = {28'h0000000, st.ien};
          default: next_st.rdata = '0;
        endcase
      end
    end
    // Convert pins three..nine, then reference
    next_st.afe_req = 1'b0;
    if (st.conv_act) begin
      if (!st.conv_wait && !cell_readout_busy) begin
        next_st.afe_req   = 1'b1;
        next_st.conv_wait = 1'b1;
      end else if (st.conv_wait && afe_valid) begin
        // Reference is always kept absolute
        if (st.ratio_sel && st.conv_idx != 3'(REF_IDX))
          code = afe_ratio_code;
        else
          code = afe_abs_code;
        next_st.meas[st.conv_idx] = code;
        next_st.conv_wait = 1'b0;
        if (st.conv_idx != 3'(REF_IDX) &&
            st.cfg[4'(st.conv_idx) + 4'(P_ANA0)] == FN_ANA &&
            (code < st.th_ot || code > st.th_ut))
          set[S_LFLT] = 1'b1;
        if (st.conv_idx == 3'(REF_IDX)) begin
          next_st.conv_act = 1'b0;
          set[S_CONV] = 1'b1;
        end else
          next_st.conv_idx = st.conv_idx + 3'h1;
      end
    end
    // Wake handling on pin seven
    wake_ok = st.wake_en && st.cfg[P_WAKE] == FN_DIN;
    wake_hi = wake_ok && st.pin_s2[P_WAKE];
    if (st.low_power) begin
      if (!wake_hi)
        next_st.wake_cnt = '0;
      else if (st.wake_cnt == WCW'(WAKE_CYC)) begin
        next_st.low_power = 1'b0;
        next_st.wake_cnt  = '0;
        set[S_WAKE] = 1'b1;
      end else
        next_st.wake_cnt = st.wake_cnt + 1'b1;
    end else if ((lnk.sleep_command || comm_timeout) && !wake_hi)
      next_st.low_power = 1'b1;
    // Fault relay downward
    set[S_FIN] = st.pin_s2[P_FIN];
    fault = st.pin_s2[P_FIN] | st.stat[S_LFLT];
    // Sticky status, set wins over clear
    next_st.stat = (st.stat & ~clr) | set;
    next_st.irq  = |(next_st.stat & st.ien);
    // Pin drivers
    for (int i = 0; i < NPIN; i++) begin
      next_st.pin_oe[i] = st.cfg[i] == FN_DOUT;
      next_st.pin_o[i]  = st.dout[i];
    end
    next_st.pin_oe[P_FIN]  = 1'b0;
    next_st.pin_oe[P_FOUT] = 1'b1;
    next_st.pin_o[P_FOUT]  = fault;
    if (spi) begin
      next_st.pin_oe[P_SCK] = 1'b0;
      next_st.pin_oe[P_SDO] = 1'b1;
      next_st.pin_o[P_SDO]  = spi_sdo;
    end
    next_st.sclk = spi & st.pin_s2[P_SCK];
    next_st.cs_n = ~spi | st.iso_s2[0];
    next_st.sdi  = spi & st.iso_s2[1];
  end

  // State register; reset gives default pin functions
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st <= '0;
      st.cfg[P_FIN]  <= FN_DIN;
      st.cfg[P_FOUT] <= FN_DOUT;
      st.cfg[P_WAKE] <= FN_DIN;
      st.cs_n        <= 1'b1;
    end else
      st <= next_st;
  end

  assign lnk.dev_o     = st.pin_o;
  assign lnk.dev_oe    = st.pin_oe;
  assign lnk.reg_rdata = st.rdata;
  assign afe_req       = st.afe_req;
  assign afe_chan      = st.conv_idx;
  assign spi_mode      = st.sel_s2 & st.loaded;
  assign spi_sclk      = st.sclk;
  assign spi_cs_n      = st.cs_n;
  assign spi_sdi       = st.sdi;
  assign low_power     = st.low_power;
  assign irq           = st.irq;
endmodule

// ---- rtl/mgw_pkg.sv ----
// Shared constants for the monitor pin block and its host end
package mgw_pkg;
  localparam int          NPIN     = 9;
  localparam int          NMEAS    = 8;
  localparam int          NST      = 4;
  // Pin function codes, two bits per pin
  localparam logic [1:0]  FN_ANA   = 2'h0;
  localparam logic [1:0]  FN_DOUT  = 2'h1;
  localparam logic [1:0]  FN_DIN   = 2'h2;
  // Pin positions (pin one sits at index 0)
  localparam int          P_FIN    = 0;
  localparam int          P_FOUT   = 1;
  localparam int          P_ANA0   = 2;
  localparam int          P_WAKE   = 6;
  localparam int          P_SCK    = 7;
  localparam int          P_SDO    = 8;
  // Register byte addresses
  localparam logic [7:0]  A_CFG    = 8'h00;
  localparam logic [7:0]  A_DOUT   = 8'h04;
  localparam logic [7:0]  A_DIN    = 8'h08;
  localparam logic [7:0]  A_CTRL   = 8'h0C;
  localparam logic [7:0]  A_TH     = 8'h10;
  localparam logic [7:0]  A_STAT   = 8'h14;
  localparam logic [7:0]  A_CLR    = 8'h18;
  localparam logic [7:0]  A_IEN    = 8'h1C;
  localparam logic [7:0]  A_MEAS   = 8'h20;
  localparam logic [7:0]  MEAS_MSK = 8'hE0;
  localparam int          REF_IDX  = 7;
  // Control register fields
  localparam int          C_RATIO  = 0;
  localparam int          C_WAKE   = 1;
  localparam int          C_CONV   = 2;
  localparam int          C_LP     = 3;
  localparam int          C_BUSY   = 4;
  // Status bits
  localparam int          S_CONV   = 0;
  localparam int          S_WAKE   = 1;
  localparam int          S_FIN    = 2;
  localparam int          S_LFLT   = 3;
  // Timing
  localparam int          CLK_MHZ  = 100;
  localparam int          WAKE_US  = 1000;
  localparam logic [1:0]  STRAP_WT = 2'h3;
  // Result scaling: absolute step in microvolts, ratio fraction bits
  localparam int          ABS_UV   = 89;
  localparam int          RAT_FRAC = 16;
  localparam logic [15:0] CHK_TOL  = 16'h0002;
endpackage

// ---- rtl/mgw_link_if.sv ----
// Pins and register path joining the monitor and its host
`timescale 1ns/1ns
interface mgw_link_if;
  logic [8:0]  dev_o;
  logic [8:0]  dev_oe;
  logic [8:0]  host_o;
  logic [8:0]  host_oe;
  logic [8:0]  pin;
  logic        serial_mode_select_pin;
  logic        isolated_minus_pin;
  logic        isolated_plus_pin;
  logic        sleep_command;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  // Wire level: device wins, then host, else weak pull-down
  assign pin = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o);
  modport dev (input pin, serial_mode_select_pin, isolated_minus_pin,
    isolated_plus_pin, sleep_command, reg_addr, reg_wdata, reg_wr,
    reg_rd, output dev_o, dev_oe, reg_rdata);
  modport host (input pin, reg_rdata, output host_o, host_oe,
    serial_mode_select_pin, isolated_minus_pin, isolated_plus_pin,
    sleep_command, reg_addr, reg_wdata, reg_wr, reg_rd);
endinterface

// ---- rtl/mgw_host.sv ----
// Host end: register master, pin drive, fault interrupt, divider check
`timescale 1ns/1ns
module mgw_host
  import mgw_pkg::*;
#(
  parameter int CHK_PIN = 0
)(
  input  wire logic        clock,
  input  wire logic        resetn,
  mgw_link_if.host         lnk,
  input  wire logic        usr_select,
  input  wire logic [8:0]  usr_pin_o,
  input  wire logic [8:0]  usr_pin_oe,
  input  wire logic        usr_cs_n,
  input  wire logic        usr_sdi,
  input  wire logic        usr_sleep,
  input  wire logic        usr_wr,
  input  wire logic        usr_rd,
  input  wire logic [7:0]  usr_addr,
  input  wire logic [31:0] usr_wdata,
  input  wire logic        check_start,
  output logic [31:0]      usr_rdata,
  output logic             usr_rvalid,
  output logic [8:0]       pin_level,
  output logic             fault_irq,
  output logic             check_busy,
  output logic             check_pass,
  output logic             check_fail
);
  initial begin
    if (CHK_PIN < 0 || CHK_PIN > 6)
      $error("CHK_PIN must be 0 to 6");
  end

  typedef enum logic [3:0] {
    H_IDLE = 4'h0, H_CLR0 = 4'h1, H_GO0  = 4'h2, H_POLL0 = 4'h3,
    H_PD0  = 4'h4, H_RPIN = 4'h5, H_PPIN = 4'h6, H_RREF  = 4'h7,
    H_PREF = 4'h8, H_CLR1 = 4'h9, H_GO1  = 4'hA, H_POLL1 = 4'hB,
    H_PD1  = 4'hC, H_RRAT = 4'hD, H_PRAT = 4'hE, H_REST  = 4'hF
  } mgw_hst_t;

  typedef struct packed {
    mgw_hst_t    fsm;
    logic [8:0]  pin_s1;
    logic [8:0]  pin_s2;
    logic [8:0]  o;
    logic [8:0]  oe;
    logic        sel;
    logic        cs_n;
    logic        sdi;
    logic        sleep;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        upend;
    logic [31:0] rdata;
    logic        rvalid;
    logic        fault;
    logic        startup;
    logic        pass;
    logic        fail;
    logic [15:0] pinv;
    logic [15:0] refv;
    logic        hold;
  } mgw_host_st_t;

  mgw_host_st_t st;
  mgw_host_st_t next_st;

  // Single next-state process
  always_comb begin
    logic [31:0] expct;
    logic [15:0] diff;
    next_st = st;
    expct   = '0;
    diff    = '0;
    next_st.pin_s1 = lnk.pin;
    next_st.pin_s2 = st.pin_s1;
    next_st.o      = usr_pin_o;
    next_st.oe     = usr_pin_oe;
    next_st.sel    = usr_select;
    next_st.cs_n   = usr_cs_n;
    next_st.sdi    = usr_sdi;
    next_st.sleep  = usr_sleep;
    next_st.fault  = st.pin_s2[P_FOUT];
    next_st.wr     = 1'b0;
    next_st.rd     = 1'b0;
    next_st.rvalid = 1'b0;
    next_st.upend  = st.rd && st.fsm == H_IDLE;
    if (st.upend) begin
      next_st.rdata  = lnk.reg_rdata;
      next_st.rvalid = 1'b1;
    end
    // Read data stand a cycle after the strobe: wait once
    next_st.hold = st.fsm inside {H_PD0, H_PD1, H_PPIN, H_PREF, H_PRAT}
                   && !st.hold;
    if (!next_st.hold)
    case (st.fsm)
      H_IDLE: begin
        if (check_start && st.startup) begin
          next_st.fsm  = H_CLR0;
          next_st.pass = 1'b0;
          next_st.fail = 1'b0;
        end else if (usr_wr || usr_rd) begin
          next_st.startup = 1'b0;
          next_st.addr    = usr_addr;
          next_st.wdata   = usr_wdata;
          next_st.wr      = usr_wr;
          next_st.rd      = usr_rd & ~usr_wr;
        end
      end
      H_CLR0, H_CLR1: begin
        next_st.addr  = A_CLR;
        next_st.wdata = 32'hFFFFFFFF;
        next_st.wr    = 1'b1;
        next_st.fsm   = (st.fsm == H_CLR0) ? H_GO0 : H_GO1;
      end
      H_GO0, H_GO1: begin
        next_st.addr  = A_CTRL;
        next_st.wdata = '0;
        next_st.wdata[C_CONV]  = 1'b1;
        next_st.wdata[C_RATIO] = st.fsm == H_GO1;
        next_st.wr    = 1'b1;
        next_st.fsm   = (st.fsm == H_GO0) ? H_POLL0 : H_POLL1;
      end
      H_POLL0, H_POLL1, H_RPIN, H_RREF, H_RRAT: begin
        next_st.rd   = 1'b1;
        next_st.addr = (st.fsm == H_POLL0 || st.fsm == H_POLL1) ?
                       A_STAT : A_MEAS;
        if (st.fsm == H_RPIN || st.fsm == H_RRAT)
          next_st.addr = A_MEAS + 8'(4 * CHK_PIN);
        if (st.fsm == H_RREF)
          next_st.addr = A_MEAS + 8'(4 * REF_IDX);
        next_st.fsm  = mgw_hst_t'(st.fsm + 4'h1);
      end
      H_PD0, H_PD1: begin
        if (lnk.reg_rdata[S_CONV])
          next_st.fsm = (st.fsm == H_PD0) ? H_RPIN : H_RRAT;
        else
          next_st.fsm = (st.fsm == H_PD0) ? H_POLL0 : H_POLL1;
      end
      H_PPIN: begin
        next_st.pinv = lnk.reg_rdata[15:0];
        next_st.fsm  = H_RREF;
      end
      H_PREF: begin
        next_st.refv = lnk.reg_rdata[15:0];
        next_st.fsm  = H_CLR1;
      end
      H_PRAT: begin
        // Absolute pin over reference, in ratio steps
        if (st.refv != 16'h0000)
          expct = {st.pinv, 16'h0000} / {16'h0000, st.refv};
        diff = (expct[15:0] > lnk.reg_rdata[15:0]) ?
               expct[15:0] - lnk.reg_rdata[15:0] :
               lnk.reg_rdata[15:0] - expct[15:0];
        next_st.pass = st.refv != 16'h0000 && expct[31:16] == 16'h0000 &&
                       diff <= CHK_TOL;
        next_st.fail = !next_st.pass;
        next_st.fsm  = H_REST;
      end
      H_REST: begin
        // Return to absolute mode before thresholds are trusted again
        next_st.addr    = A_CTRL;
        next_st.wdata   = '0;
        next_st.wr      = 1'b1;
        next_st.startup = 1'b0;
        next_st.fsm     = H_IDLE;
      end
      default: next_st.fsm = H_IDLE;
    endcase
  end

  // Register the state
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st         <= '0;
      st.fsm     <= H_IDLE;
      st.cs_n    <= 1'b1;
      st.startup <= 1'b1;
    end else
      st <= next_st;
  end

  assign lnk.host_o                 = st.o;
  assign lnk.host_oe                = st.oe;
  assign lnk.serial_mode_select_pin = st.sel;
  assign lnk.isolated_minus_pin     = st.cs_n;
  assign lnk.isolated_plus_pin      = st.sdi;
  assign lnk.sleep_command          = st.sleep;
  assign lnk.reg_addr               = st.addr;
  assign lnk.reg_wdata              = st.wdata;
  assign lnk.reg_wr                 = st.wr;
  assign lnk.reg_rd                 = st.rd;
  assign usr_rdata                  = st.rdata;
  assign usr_rvalid                 = st.rvalid;
  assign pin_level                  = st.pin_s2;
  assign fault_irq                  = st.fault;
  assign check_busy                 = st.fsm != H_IDLE;
  assign check_pass                 = st.pass;
  assign check_fail                 = st.fail;
endmodule

// ---- sim/mgw_link_props.sv ----
// Checker on the pins and register path between monitor and host ends
`timescale 1ns/1ns
module mgw_link_props
  import mgw_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [8:0]  dev_oe,
  input wire logic [8:0]  pin,
  input wire logic        serial_mode_select_pin,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata
);
  // Single clock domain
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_fin_in; resetn [*3] |-> !dev_oe[P_FIN]; endproperty
  a_fin_in: assert property (p_fin_in)
    else $error("fault input pin driven by monitor");
  property p_fout; resetn [*3] |-> dev_oe[P_FOUT]; endproperty
  a_fout: assert property (p_fout)
    else $error("fault output pin not driven");
  property p_relay; pin[P_FIN] [*5] |-> pin[P_FOUT]; endproperty
  a_relay: assert property (p_relay)
    else $error("upper fault not relayed downward");
  property p_cfg_lock;
    reg_rd && reg_addr == A_CFG |=> reg_rdata[3:0] == {FN_DOUT, FN_DIN};
  endproperty
  a_cfg_lock: assert property (p_cfg_lock)
    else $error("fault pin functions not locked");
  // Strap needs a few cycles to settle
  property p_sdo_out;
    serial_mode_select_pin [*8] |-> ##2 dev_oe[P_SDO];
  endproperty
  a_sdo_out: assert property (p_sdo_out)
    else $error("serial out pin not driven in serial mode");
  property p_ana9;
    !serial_mode_select_pin [*8] |-> ##2 !dev_oe[P_SDO];
  endproperty
  a_ana9: assert property (p_ana9)
    else $error("pin nine driven outside serial mode");
  property p_sck_in; resetn [*8] |-> !dev_oe[P_SCK]; endproperty
  a_sck_in: assert property (p_sck_in)
    else $error("serial clock pin driven by monitor");
  property p_dout;
    reg_wr && reg_addr == A_CFG && reg_wdata[5:4] == FN_DOUT
      |-> ##[1:4] dev_oe[P_ANA0];
  endproperty
  a_dout: assert property (p_dout)
    else $error("pin three not driven after output config");
endmodule

// ---- sim/test_monitor_gpio_config_wake_fault.sv ----
// Testbench joining monitor and host ends across the link
`timescale 1ns/1ns
module test_monitor_gpio_config_wake_fault;
  import mgw_pkg::*;
  logic        clock = 1'b0, resetn = 1'b0, usr_select = 1'b0;
  logic        usr_cs_n = 1'b1, usr_sdi = 1'b0, usr_sleep = 1'b0;
  logic        usr_wr = 1'b0, usr_rd = 1'b0, check_start = 1'b0;
  logic        cell_readout_busy = 1'b0, comm_timeout = 1'b0;
  logic        afe_valid = 1'b0, spi_sdo = 1'b0;
  logic [15:0] afe_abs_code = 16'h0000, afe_ratio_code = 16'h0000;
  logic [8:0]  usr_pin_o = 9'h000, usr_pin_oe = 9'h000, pin_level;
  logic [7:0]  usr_addr = 8'h00;
  logic [31:0] usr_wdata = 32'h0, usr_rdata;
  logic [2:0]  afe_chan;
  logic        afe_req, spi_mode, spi_sclk, spi_cs_n, spi_sdi;
  logic        low_power, irq, usr_rvalid, fault_irq;
  logic        check_busy, check_pass, check_fail;
  int          n_mismatch = 0, checked = 0;

  mgw_link_if lnk ();
  mgw_dev #(.WAKE_CYC(20)) i_mgw_dev (.clock(clock), .resetn(resetn),
    .lnk(lnk), .cell_readout_busy(cell_readout_busy),
    .comm_timeout(comm_timeout), .afe_valid(afe_valid),
    .afe_abs_code(afe_abs_code), .afe_ratio_code(afe_ratio_code),
    .spi_sdo(spi_sdo), .afe_req(afe_req), .afe_chan(afe_chan),
    .spi_mode(spi_mode), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .low_power(low_power), .irq(irq));
  mgw_host i_mgw_host (.clock(clock), .resetn(resetn), .lnk(lnk),
    .usr_select(usr_select), .usr_pin_o(usr_pin_o),
    .usr_pin_oe(usr_pin_oe), .usr_cs_n(usr_cs_n), .usr_sdi(usr_sdi),
    .usr_sleep(usr_sleep), .usr_wr(usr_wr), .usr_rd(usr_rd),
    .usr_addr(usr_addr), .usr_wdata(usr_wdata),
    .check_start(check_start), .usr_rdata(usr_rdata),
    .usr_rvalid(usr_rvalid), .pin_level(pin_level), .fault_irq(fault_irq),
    .check_busy(check_busy), .check_pass(check_pass),
    .check_fail(check_fail));
  mgw_link_props i_mgw_link_props (.clock(clock), .resetn(resetn),
    .dev_oe(lnk.dev_oe), .pin(lnk.pin),
    .serial_mode_select_pin(lnk.serial_mode_select_pin),
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
    .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_rdata(lnk.reg_rdata));

  // 100 MHz clock
  always #5 clock = ~clock;

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic timeout;
    n_mismatch++;
    $display("CHECK FAILED wait_bound expected 1 seen 0");
    finish_test();
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Front end stand-in, answers a cycle after each request
  always @(posedge clock) begin
    afe_valid <= afe_req;
    afe_abs_code <= (afe_chan == 3'h7) ? 16'h2000 :
                    {5'h00, afe_chan + 3'h1, 8'h00};
    afe_ratio_code <= {2'h0, afe_chan + 3'h1, 11'h000};
    if (cell_readout_busy) chk("req_in_readout", 32'(afe_req), 0);
  end

  // Drive after rising edges, sample at falling ones
  task automatic sam(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    usr_addr <= a;
    usr_wdata <= d;
    usr_wr <= 1'b1;
    @(posedge clock) usr_wr <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge clock);
    usr_addr <= a;
    usr_rd <= 1'b1;
    @(posedge clock) usr_rd <= 1'b0;
    for (k = 0; k < 8; k++) begin
      @(negedge clock);
      if (usr_rvalid === 1'b1) break;
    end
    d = usr_rdata;
    if (k == 8) timeout();
  endtask

  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask

  task automatic do_reset(input logic sel);
    @(posedge clock);
    resetn <= 1'b0;
    usr_select <= sel;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (12) @(posedge clock);
  endtask

  // Divider check, cell readout busy at first
  task automatic t_check;
    int k;
    @(posedge clock);
    check_start <= 1'b1;
    cell_readout_busy <= 1'b1;
    @(posedge clock) check_start <= 1'b0;
    repeat (10) @(posedge clock);
    cell_readout_busy <= 1'b0;
    for (k = 0; k < 600; k++) begin
      @(negedge clock);
      if (check_pass === 1'b1 || check_fail === 1'b1) break;
    end
    if (k == 600) timeout();
    chk("check_result", {check_pass, check_fail}, 32'h2);
  endtask

  task automatic t_pins;
    logic [31:0] d;
    rdc("cfg_default", A_CFG, 32'h0000_2006);
    rdc("unmapped", 8'h40, 32'h0);
    @(posedge clock);
    usr_pin_oe <= 9'h008;
    usr_pin_o <= 9'h008;
    wr(A_CFG, 32'h0000_2099);
    rdc("cfg_locked", A_CFG, 32'h0000_2096);
    wr(A_DOUT, 32'h0000_0004);
    sam(4);
    chk("dout_pin3_high", 32'(pin_level[2]), 1);
    rd(A_DIN, d);
    chk("din_pin4", 32'(d[3]), 1);
    wr(A_DOUT, 32'h0);
    sam(4);
    chk("dout_pin3_low", 32'(pin_level[2]), 0);
    @(posedge clock);
    usr_pin_oe <= 9'h000;
    wr(A_CFG, 32'h0000_2006);
  endtask

  task automatic t_conv;
    logic [31:0] d;
    int r, k;
    wr(A_TH, 32'hFFFF_0000);
    for (r = 0; r < 2; r++) begin
      wr(A_CLR, 32'h0000_000F);
      wr(A_CTRL, {29'h0, 1'b1, 1'b0, r[0]});
      for (k = 0; k < 40; k++) begin
        rd(A_STAT, d);
        if (d[S_CONV] === 1'b1) break;
      end
      if (k == 40) timeout();
      rdc("meas_pin5", A_MEAS + 8'h08, r ? 32'h1800 : 32'h0300);
      rdc("meas_ref", A_MEAS + 8'h1C, 32'h0000_2000);
    end
    rdc("thresholds_kept", A_TH, 32'hFFFF_0000);
  endtask

  // Fault relay and interrupt
  task automatic t_fault;
    wr(A_CLR, 32'h0000_000F);
    wr(A_IEN, 32'h0000_0004);
    sam(8);
    chk("fault_idle", {fault_irq, irq, pin_level[1]}, 0);
    @(posedge clock);
    usr_pin_oe <= 9'h001;
    usr_pin_o <= 9'h001;
    sam(8);
    chk("fault_relay", {fault_irq, irq, pin_level[1]}, 32'h7);
    wr(A_IEN, 32'h0);
    sam(2);
    chk("irq_masked", 32'(irq), 0);
    @(posedge clock) usr_pin_o <= 9'h000;
    sam(4);
    wr(A_CLR, 32'h0000_000F);
    sam(8);
    chk("fault_gone", {fault_irq, pin_level[1]}, 0);
    rdc("stat_cleared", A_STAT, 32'h0);
  endtask

  task automatic t_wake;
    wr(A_CTRL, 32'h0000_0002);
    @(posedge clock) usr_sleep <= 1'b1;
    @(posedge clock) usr_sleep <= 1'b0;
    sam(4);
    chk("sleep_entered", 32'(low_power), 1);
    @(posedge clock);
    usr_pin_oe <= 9'h040;
    usr_pin_o <= 9'h040;
    sam(12);
    chk("wake_filtered", 32'(low_power), 1);
    sam(20);
    chk("woken", 32'(low_power), 0);
    @(posedge clock);
    usr_sleep <= 1'b1;
    comm_timeout <= 1'b1;
    @(posedge clock);
    usr_sleep <= 1'b0;
    comm_timeout <= 1'b0;
    sam(4);
    chk("kept_awake", 32'(low_power), 0);
    @(posedge clock) usr_pin_o <= 9'h000;
    sam(4);
    @(posedge clock) comm_timeout <= 1'b1;
    @(posedge clock) comm_timeout <= 1'b0;
    sam(4);
    chk("timeout_sleep", 32'(low_power), 1);
    wr(A_CFG, 32'h0000_0006);
    @(posedge clock) usr_pin_o <= 9'h040;
    sam(40);
    chk("wake_needs_input", 32'(low_power), 1);
    wr(A_CFG, 32'h0000_2006);
    wr(A_CTRL, 32'h0);
    sam(40);
    chk("wake_needs_enable", 32'(low_power), 1);
    @(posedge clock) usr_pin_oe <= 9'h000;
  endtask

  task automatic t_serial;
    @(posedge clock);
    usr_cs_n <= 1'b0;
    usr_sdi <= 1'b1;
    spi_sdo <= 1'b1;
    usr_pin_oe <= 9'h080;
    usr_pin_o <= 9'h080;
    sam(6);
    chk("serial_in", {spi_mode, spi_cs_n, spi_sdi, spi_sclk}, 32'hB);
    chk("sdo_high", 32'(pin_level[8]), 1);
    @(posedge clock) spi_sdo <= 1'b0;
    sam(6);
    chk("sdo_low", 32'(pin_level[8]), 0);
    wr(A_CFG, 32'h0000_2006);
    rdc("cfg_serial", A_CFG, 32'h0001_A006);
  endtask

  // Divider check must precede any register command
  initial begin
    do_reset(1'b0);
    t_check();
    t_pins();
    t_conv();
    t_fault();
    t_wake();
    do_reset(1'b1);
    t_serial();
    finish_test();
  end
endmodule
